/* hdl/imbra_pkg.sv */
// Package for the multi-byte I2C register access engine
package imbra_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned SCL_HZ_DEFAULT = 100000;
  // Quarter bit period in system cycles, rounded down
  localparam int unsigned QTR_CYC = CLK_HZ / (SCL_HZ_DEFAULT * 4);
  localparam logic [1:0] STS_OK = 2'h0;
  localparam logic [1:0] STS_NACK_ADDR = 2'h1;
  localparam logic [1:0] STS_NACK_DATA = 2'h2;
  localparam logic [1:0] STS_BAD_REQ = 2'h3;
  localparam logic [2:0] BYTES_HALF = 3'h2;
  localparam logic [2:0] BYTES_WORD = 3'h4;

  typedef struct packed {
    logic write_halfword_request;
    logic read_halfword_request;
    logic write_word_request;
    logic read_word_request;
    logic [6:0] target_device_id;
    logic [7:0] start_register_index;
    logic [31:0] transfer_value;
  } imbra_req_t;

  typedef struct packed {
    logic done;
    logic [1:0] status;
    logic [31:0] transfer_value;
  } imbra_rsp_t;
endpackage : imbra_pkg

/* hdl/imbra_engine.sv */
// I2C master engine for 16 and 32 bit multi-register writes and reads
`timescale 1ns/1ps
module imbra_engine #(
  parameter int unsigned QTR = imbra_pkg::QTR_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire imbra_pkg::imbra_req_t i_req,
  output logic o_busy,
  output imbra_pkg::imbra_rsp_t o_rsp,
  input wire logic i_scl,
  output logic o_scl,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe
);
  import imbra_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_START, S_BIT, S_ACK, S_RESTART, S_STOP, S_DONE
  } imbra_state_t;

  // Phases of the byte sequence
  typedef enum logic [2:0] {
    P_ADDR_W, P_REG, P_WDATA, P_ADDR_R, P_RDATA
  } imbra_phase_t;

  imbra_state_t state_ff;
  imbra_phase_t phase_ff;
  logic [15:0] tick_ff;
  logic [1:0] qtr_ff;
  logic [3:0] bit_ff;
  logic [7:0] shift_ff;
  logic [2:0] left_ff;
  logic [2:0] total_ff;
  logic is_read_ff;
  logic [6:0] dev_ff;
  logic [7:0] reg_ff;
  logic [31:0] val_ff;
  logic [31:0] rdata_ff;
  logic [1:0] status_ff;
  logic done_ff;
  logic scl_low_ff;
  logic sda_low_ff;
  logic tick_end;
  logic any_req;
  logic [2:0] req_cnt;

  // Count of raised strobes; more than one is refused
  function automatic logic [2:0] count_req(input imbra_req_t r);
    count_req = {2'h0, r.write_halfword_request} + {2'h0, r.read_halfword_request}
              + {2'h0, r.write_word_request} + {2'h0, r.read_word_request};
  endfunction : count_req

  // Halfword strobes set both the value width and the register count
  function automatic logic is_half(input imbra_req_t r);
    is_half = r.write_halfword_request || r.read_halfword_request;
  endfunction : is_half

  assign req_cnt = count_req(i_req);
  assign any_req = (req_cnt != 3'h0);
  assign tick_end = (tick_ff == 16'(QTR - 1));
  assign o_busy = (state_ff != S_IDLE);
  assign o_rsp = '{done: done_ff, status: status_ff, transfer_value: rdata_ff};
  // Open drain: drive only low
  assign o_scl = 1'b0;
  assign o_sda = 1'b0;
  assign o_scl_oe = scl_low_ff;
  assign o_sda_oe = sda_low_ff;

  // Quarter-bit timebase; a held-low clock from the slave stretches the bit
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tick_ff <= 16'h0;
    end else if (state_ff == S_IDLE || state_ff == S_DONE || tick_end) begin
      tick_ff <= 16'h0;
    end else if (!(qtr_ff == 2'h2 && !scl_low_ff && !i_scl)) begin
      tick_ff <= tick_ff + 16'h1;
    end
  end

  // Main sequencer
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_ff <= S_IDLE;
      phase_ff <= P_ADDR_W;
      qtr_ff <= 2'h0;
      bit_ff <= 4'h0;
      shift_ff <= 8'h0;
      left_ff <= 3'h0;
      total_ff <= 3'h0;
      is_read_ff <= 1'b0;
      dev_ff <= 7'h0;
      reg_ff <= 8'h0;
      val_ff <= 32'h0;
      rdata_ff <= 32'h0;
      status_ff <= STS_OK;
      done_ff <= 1'b0;
      scl_low_ff <= 1'b0;
      sda_low_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          scl_low_ff <= 1'b0;
          sda_low_ff <= 1'b0;
          qtr_ff <= 2'h0;
          if (req_cnt > 3'h1) begin
            status_ff <= STS_BAD_REQ;
            done_ff <= 1'b1;
          end else if (any_req) begin
            dev_ff <= i_req.target_device_id;
            reg_ff <= i_req.start_register_index;
            val_ff <= is_half(i_req) ?
                      {i_req.transfer_value[15:0], 16'h0} : i_req.transfer_value;
            total_ff <= is_half(i_req) ? BYTES_HALF : BYTES_WORD;
            is_read_ff <= i_req.read_halfword_request || i_req.read_word_request;
            rdata_ff <= 32'h0;
            status_ff <= STS_OK;
            phase_ff <= P_ADDR_W;
            state_ff <= S_START;
          end
        end
        S_START, S_RESTART: begin
          if (tick_end) begin
            qtr_ff <= qtr_ff + 2'h1;
            case (qtr_ff)
              2'h0: begin
                sda_low_ff <= 1'b0;
                scl_low_ff <= 1'b0;
              end
              2'h1: sda_low_ff <= 1'b1;
              2'h2: scl_low_ff <= 1'b1;
              default: begin
                bit_ff <= 4'h0;
                shift_ff <= (state_ff == S_START) ? {dev_ff, 1'b0} : {dev_ff, 1'b1};
                left_ff <= total_ff;
                state_ff <= S_BIT;
              end
            endcase
          end
        end
        S_BIT, S_ACK: begin
          if (tick_end) begin
            qtr_ff <= qtr_ff + 2'h1;
            case (qtr_ff)
              2'h0: begin
                if (state_ff == S_BIT) begin
                  sda_low_ff <= (phase_ff == P_RDATA) ? 1'b0 : !shift_ff[7];
                end else begin
                  // Master acks every read byte but the last
                  sda_low_ff <= (phase_ff == P_RDATA) && (left_ff != 3'h1);
                end
              end
              2'h1: scl_low_ff <= 1'b0;
              2'h2: begin
                if (state_ff == S_BIT) begin
                  shift_ff <= {shift_ff[6:0], i_sda};
                end else if (phase_ff != P_RDATA && i_sda) begin
                  status_ff <= (phase_ff == P_ADDR_W || phase_ff == P_ADDR_R) ?
                               STS_NACK_ADDR : STS_NACK_DATA;
                end
              end
              default: begin
                scl_low_ff <= 1'b1;
                if (state_ff == S_BIT) begin
                  bit_ff <= bit_ff + 4'h1;
                  if (bit_ff == 4'h7) begin
                    state_ff <= S_ACK;
                    if (phase_ff == P_RDATA) begin
                      // first byte read is most significant
                      rdata_ff <= {rdata_ff[23:0], shift_ff};
                    end
                  end
                end else begin
                  bit_ff <= 4'h0;
                  state_ff <= S_BIT;
                  case (phase_ff)
                    P_ADDR_W: begin
                      phase_ff <= P_REG;
                      shift_ff <= reg_ff;
                    end
                    P_REG: begin
                      if (is_read_ff) begin
                        phase_ff <= P_ADDR_R;
                        state_ff <= S_RESTART;
                        sda_low_ff <= 1'b0;
                      end else begin
                        phase_ff <= P_WDATA;
                        shift_ff <= val_ff[31:24];
                        val_ff <= {val_ff[23:0], 8'h0};
                      end
                    end
                    P_WDATA: begin
                      left_ff <= left_ff - 3'h1;
                      shift_ff <= val_ff[31:24];
                      val_ff <= {val_ff[23:0], 8'h0};
                      if (left_ff == 3'h1) begin
                        state_ff <= S_STOP;
                      end
                    end
                    P_ADDR_R: phase_ff <= P_RDATA;
                    default: begin
                      left_ff <= left_ff - 3'h1;
                      if (left_ff == 3'h1) begin
                        state_ff <= S_STOP;
                      end
                    end
                  endcase
                  // refused byte ends in a real stop, clock already low
                  if (status_ff != STS_OK) begin
                    state_ff <= S_STOP;
                  end
                end
              end
            endcase
          end
        end
        S_STOP: begin
          if (tick_end) begin
            qtr_ff <= qtr_ff + 2'h1;
            case (qtr_ff)
              2'h0: sda_low_ff <= 1'b1;
              2'h1: scl_low_ff <= 1'b0;
              2'h2: sda_low_ff <= 1'b0;
              default: state_ff <= S_DONE;
            endcase
          end
        end
        S_DONE: begin
          done_ff <= 1'b1;
          state_ff <= S_IDLE;
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end
endmodule : imbra_engine

/* tb/imbra_engine_sva.sv */
// Port checks for the multi-byte register engine
`timescale 1ns/1ps
module imbra_engine_sva #(
  parameter int unsigned QTR = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire imbra_pkg::imbra_req_t i_req,
  input wire logic o_busy,
  input wire imbra_pkg::imbra_rsp_t o_rsp,
  input wire logic o_scl_oe,
  input wire logic o_sda_oe
);
  import imbra_pkg::*;
  logic [3:0] stb;
  logic [15:0] busy_cnt_ff;
  assign stb = i_req[50:47];
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // Counter, since a word read outlasts any delay range
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      busy_cnt_ff <= 16'h0;
    end else begin
      busy_cnt_ff <= o_busy ? busy_cnt_ff + 16'h1 : 16'h0;
    end
  end
  sequence s_take;
    !o_busy && $onehot(stb);
  endsequence
  sequence s_bad;
    !o_busy && $countones(stb) > 1;
  endsequence
  sequence s_start;
    o_sda_oe && !o_scl_oe;
  endsequence
  a_accept_goes_busy: assert property (s_take |=> o_busy
    && o_rsp.transfer_value == 32'h0 && o_rsp.status == STS_OK)
    else $error("request not taken");
  a_bad_refused: assert property (s_bad |=> o_rsp.done && !o_busy && o_rsp.status == STS_BAD_REQ)
    else $error("bad request not refused");
  a_idle_bus_free: assert property (!o_busy |-> !o_scl_oe && !o_sda_oe)
    else $error("bus driven while idle");
  a_done_one_pulse: assert property (o_rsp.done |=> !o_rsp.done)
    else $error("done longer than one cycle");
  a_busy_ends_done: assert property ($fell(o_busy) |-> o_rsp.done)
    else $error("busy fell without done");
  a_result_holds: assert property (!o_busy && stb == 4'h0 |=> $stable(o_rsp.status)
    && $stable(o_rsp.transfer_value)) else $error("result changed while idle");
  a_start_soon: assert property (s_take ##1 o_busy |-> ##[1:64] s_start)
    else $error("no start condition");
  a_busy_bounded: assert property (busy_cnt_ff < 16'(QTR * 320))
    else $error("transfer too long");
endmodule : imbra_engine_sva
bind imbra_engine imbra_engine_sva #(.QTR(QTR)) u_sva (.i_clk_sys(i_clk_sys),
  .i_sys_rst(i_sys_rst), .i_req(i_req), .o_busy(o_busy), .o_rsp(o_rsp),
  .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe));

/* tb/imbra_slave.sv */
// Behavioural I2C slave holding 256 byte registers
`timescale 1ns/1ps
module imbra_slave #(
  parameter logic [6:0] ADDR = 7'h2c
) (
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_nack_data,
  output logic o_sda_oe
);
  logic [7:0] regs [256];
  logic [7:0] sh;
  logic [7:0] ptr;
  logic act = 1'b0;
  logic rd;
  logic stop_rd;
  int cnt;
  int idx;
  initial o_sda_oe = 1'b0;
  // Start or repeated start restarts framing
  always @(negedge i_sda) if (i_scl) begin
    act = 1'b1;
    cnt = 0;
    idx = 0;
    rd = 1'b0;
    stop_rd = 1'b0;
  end
  always @(posedge i_sda) if (i_scl) act = 1'b0;
  always @(posedge i_scl) if (act) begin
    if (cnt < 8) sh = {sh[6:0], i_sda};
    if (cnt == 8 && rd) stop_rd = i_sda;
    cnt++;
  end
  // Changes only while the clock is low, so no false start or stop
  always @(negedge i_scl) if (act) begin
    if (cnt == 8 && !rd) begin
      if (idx == 0) begin
        act = (sh[7:1] == ADDR);
        rd = sh[0];
      end else if (idx == 1) begin
        ptr = sh;
      end else if (!i_nack_data) begin
        regs[ptr] = sh;
        ptr++;
      end
      o_sda_oe = act && !(idx > 1 && i_nack_data);
    end else if (cnt == 8) begin
      o_sda_oe = 1'b0;
      ptr++;
    end else if (cnt == 9) begin
      cnt = 0;
      idx++;
      o_sda_oe = rd && !stop_rd && !regs[ptr][7];
    end else if (rd && !stop_rd) begin
      o_sda_oe = !regs[ptr][7 - cnt];
    end
  end
endmodule : imbra_slave

/* tb/imbra_engine_test.sv */
// Self-checking bench for the multi-byte register engine
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module imbra_engine_test;
  import imbra_pkg::*;
  localparam logic [6:0] DEV = 7'h2c;
  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  logic nack_data = 1'b0;
  imbra_req_t req = '0;
  imbra_rsp_t rsp;
  logic busy, scl_oe, sda_oe, slv_oe, scl_drv, sda_drv;
  logic [1:0] st;
  logic [31:0] d;
  // Pull-ups win when nobody drives
  wire scl = scl_oe ? scl_drv : 1'b1;
  wire sda = (sda_oe ? sda_drv : 1'b1) && !slv_oe;
  int miscompares = 0;
  int n_compared = 0;
  int seed = 21;
  always #4 i_clk_sys = !i_clk_sys;
  imbra_engine #(.QTR(4)) dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_req(req),
    .o_busy(busy), .o_rsp(rsp), .i_scl(scl), .o_scl(scl_drv), .o_scl_oe(scl_oe), .i_sda(sda),
    .o_sda(sda_drv), .o_sda_oe(sda_oe));
  imbra_slave #(.ADDR(DEV)) slave (.i_scl(scl), .i_sda(sda), .i_nack_data(nack_data),
    .o_sda_oe(slv_oe));
  task automatic complete_run;
    if (miscompares == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  // Big-endian: first register lands highest
  function automatic logic [31:0] assemble(input logic [7:0] ri, input int nb);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < nb; i++) r = {r[23:0], slave.regs[8'(ri + i)]};
    return r;
  endfunction : assemble
  task automatic run(input logic [3:0] stb, input logic [7:0] ri, input logic [31:0] v,
      input logic [6:0] dv);
    int n;
    n = 0;
    @(negedge i_clk_sys);
    req = {stb, dv, ri, v};
    @(negedge i_clk_sys);
    req[50:47] = 4'h0;
    while (rsp.done !== 1'b1 && n < 4000) begin
      @(negedge i_clk_sys);
      n++;
    end
    `CHK(rsp.done, 1'b1)
    st = rsp.status;
    d = rsp.transfer_value;
  endtask : run
  task automatic op(input logic [3:0] stb, input logic [7:0] ri, input logic [31:0] v);
    logic [7:0] nxt;
    logic [31:0] e;
    nxt = slave.regs[8'(ri + 2)];
    e = assemble(ri, stb[2] ? 2 : 4);
    run(stb, ri, v, DEV);
    `CHK(st, STS_OK)
    case (stb)
      4'h8: `CHK(assemble(ri, 3), {8'h0, v[15:0], nxt})
      4'h4: `CHK(d, e)
      4'h2: `CHK(assemble(ri, 4), v)
      default: `CHK(d, e)
    endcase
  endtask : op
  initial begin
    repeat (16) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    `CHK({busy, rsp}, 36'h0)
    i_sys_rst = 1'b0;
    for (int i = 0; i < 256; i++) slave.regs[i] = 8'($random(seed));
    op(4'h8, 8'h34, 32'hdead4210);
    op(4'h2, 8'hfe, 32'h4210fedc);
    op(4'h4, 8'hff, 32'h0);
    op(4'h1, 8'h00, 32'h0);
    for (int k = 0; k < 8; k++) op(4'h1 << ($random(seed) & 3), 8'($random(seed)), $random(seed));
    run(4'h1, 8'h10, 32'h0, DEV ^ 7'h01);
    `CHK(st, STS_NACK_ADDR)
    nack_data = 1'b1;
    run(4'h2, 8'h10, 32'h12345678, DEV);
    `CHK(st, STS_NACK_DATA)
    nack_data = 1'b0;
    run(4'h5, 8'h10, 32'h0, DEV);
    `CHK(st, STS_BAD_REQ)
    // Status must read zero again after failures
    op(4'h4, 8'h10, 32'h0);
    complete_run();
  end
  initial begin
    repeat (60000) @(posedge i_clk_sys);
    miscompares++;
    complete_run();
  end
endmodule : imbra_engine_test
